// ### rtl/spp_pkg.sv
package spp_pkg;

  // register map, byte addresses on the 8-bit bus address
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0]  OFF_CTRL = 8'h00;
  localparam logic [7:0]  OFF_CFG  = 8'h04;

  // serial_parallel_port_ctrl field positions
  localparam int unsigned B_HP_EN     = 0;
  localparam int unsigned B_HP_CS_N   = 1;
  localparam int unsigned B_HP_STRB   = 2;
  localparam int unsigned B_HP_RW     = 3;
  localparam int unsigned B_HP_ACK    = 4;
  localparam int unsigned B_HP_OE_N   = 5;
  localparam int unsigned B_HP_DATA   = 6;
  localparam int unsigned B_HP_ADDR   = 14;
  localparam int unsigned B_DDC_EN    = 18;
  localparam int unsigned B_DDC_CK_W  = 19;
  localparam int unsigned B_DDC_DA_W  = 20;
  localparam int unsigned B_DDC_CK_R  = 21;
  localparam int unsigned B_DDC_DA_R  = 22;
  localparam int unsigned B_I2C_EN    = 23;
  localparam int unsigned B_I2C_CK_W  = 24;
  localparam int unsigned B_I2C_DA_W  = 25;
  localparam int unsigned B_I2C_CK_R  = 26;
  localparam int unsigned B_I2C_DA_R  = 27;
  localparam int unsigned B_VID_RST_N = 28;
  localparam int unsigned B_GPIO1     = 29;
  localparam int unsigned B_GPIO2     = 30;
  localparam int unsigned B_TV_RST_N  = 31;

  // reset value and the bits software may store
  localparam logic [31:0] CTRL_RST  = 32'h0318_0022;
  localparam logic [31:0] CTRL_WMSK = 32'hB39F_FFEF;

  // configuration register fields
  localparam int unsigned B_VS_LOW   = 0;
  localparam int unsigned B_HS_LOW   = 1;
  localparam int unsigned B_VA_LOW   = 2;
  localparam int unsigned B_FIELD_EV = 8;
  localparam int unsigned B_VS_ACT   = 9;
  localparam int unsigned B_HS_ACT   = 10;
  localparam int unsigned B_VA_ACT   = 11;
  localparam logic [2:0]  CFG_RST    = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } spp_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } spp_axi_rsp_s;

  // parallel host port outputs toward the video module
  typedef struct packed {
    logic       cs_n;
    logic       data_strobe_low;
    logic       rw_n;
    logic [3:0] addr;
    logic [7:0] data_o;
    logic       data_oe;
  } spp_hp_s;

  // whole state of the port block
  typedef struct packed {
    logic [31:0]       ctrl;
    logic [2:0]        cfg;
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              vs_prev;
    logic              field_even;
  } spp_state_s;

endpackage

// ### rtl/spp_port.sv
`timescale 1ns/1ps
module spp_port (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // register bus
  input  wire spp_pkg::spp_axi_req_s axi_req,
  output spp_pkg::spp_axi_rsp_s      axi_rsp,
  // parallel host port
  output spp_pkg::spp_hp_s           hp_o,
  input  wire logic [7:0]            hp_data_i,
  input  wire logic                  hp_ack_i,
  // shared pin ownership from the ROM interface
  input  wire logic                  rom_busy_i,
  // general purpose pins
  output logic                       gpio0_o,
  output logic                       gpio1_o,
  input  wire logic                  gpio2_i,
  // video input timing
  input  wire logic                  vin_vsync_i,
  input  wire logic                  vin_hsync_i,
  input  wire logic                  vin_vactive_i,
  // display data channel, open drain
  input  wire logic                  display_channel_clock_i,
  output logic                       display_channel_clock_o,
  output logic                       display_channel_clock_oe,
  input  wire logic                  display_channel_data_i,
  output logic                       display_channel_data_o,
  output logic                       display_channel_data_oe,
  // I2C, open drain
  input  wire logic                  i2c_clk_i,
  output logic                       i2c_clk_o,
  output logic                       i2c_clk_oe,
  input  wire logic                  i2c_data_i,
  output logic                       i2c_data_o,
  output logic                       i2c_data_oe,
  // external device resets
  output logic                       vid_reset_n,
  output logic                       tv_reset_n
);

  spp_pkg::spp_state_s s_q;
  spp_pkg::spp_state_s s_d;
  logic                vs_act;
  logic                hs_act;
  logic                va_act;
  logic                aw_hs;
  logic                w_hs;
  logic                ar_hs;
  logic [31:0]         ctrl_rd;
  logic [31:0]         cfg_rd;

  // polarity bit set means the signal is active low
  assign vs_act = vin_vsync_i ^ s_q.cfg[spp_pkg::B_VS_LOW];
  assign hs_act = vin_hsync_i ^ s_q.cfg[spp_pkg::B_HS_LOW];
  assign va_act = vin_vactive_i ^ s_q.cfg[spp_pkg::B_VA_LOW];

  // bus handshakes; one outstanding write and one read at a time
  assign aw_hs = axi_req.awvalid & axi_rsp.awready;
  assign w_hs  = axi_req.wvalid & axi_rsp.wready;
  assign ar_hs = axi_req.arvalid & axi_rsp.arready;

  // read views mix stored bits with live pin levels
  always_comb
  begin
    ctrl_rd = s_q.ctrl;
    ctrl_rd[spp_pkg::B_HP_ACK] = hp_ack_i;
    if (!hp_o.data_oe)
    begin
      ctrl_rd[spp_pkg::B_HP_DATA +: 8] = hp_data_i;
    end
    ctrl_rd[spp_pkg::B_DDC_CK_R] = display_channel_clock_i;
    ctrl_rd[spp_pkg::B_DDC_DA_R] = display_channel_data_i;
    ctrl_rd[spp_pkg::B_I2C_CK_R] = i2c_clk_i;
    ctrl_rd[spp_pkg::B_I2C_DA_R] = i2c_data_i;
    ctrl_rd[spp_pkg::B_GPIO2]    = gpio2_i;
    cfg_rd = 32'h0000_0000;
    cfg_rd[2:0] = s_q.cfg;
    cfg_rd[spp_pkg::B_FIELD_EV] = s_q.field_even;
    cfg_rd[spp_pkg::B_VS_ACT]   = vs_act;
    cfg_rd[spp_pkg::B_HS_ACT]   = hs_act;
    cfg_rd[spp_pkg::B_VA_ACT]   = va_act;
  end

  // next-state logic for bus slave, registers and field detector
  always_comb
  begin
    s_d = s_q;
    // write channels may arrive in either order
    if (aw_hs)
    begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (w_hs)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    if (s_q.aw_got && s_q.w_got)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = spp_pkg::RESP_OKAY;
      if (s_q.aw_addr[spp_pkg::ADDR_W-1:2] == spp_pkg::OFF_CTRL[spp_pkg::ADDR_W-1:2])
      begin
        // read-only bits are masked so a write never disturbs them
        for (int b = 0; b < 4; b++)
        begin
          if (s_q.wstrb[b])
          begin
            s_d.ctrl[8*b +: 8] = (s_q.wdata[8*b +: 8] & spp_pkg::CTRL_WMSK[8*b +: 8])
                               | (s_q.ctrl[8*b +: 8] & ~spp_pkg::CTRL_WMSK[8*b +: 8]);
          end
        end
      end
      else if (s_q.aw_addr[spp_pkg::ADDR_W-1:2] == spp_pkg::OFF_CFG[spp_pkg::ADDR_W-1:2])
      begin
        if (s_q.wstrb[0])
        begin
          s_d.cfg = s_q.wdata[2:0];
        end
      end
      else
      begin
        s_d.bresp = spp_pkg::RESP_SLVERR;
      end
    end
    if (s_q.bvalid && axi_req.bready)
    begin
      s_d.bvalid = 1'b0;
    end
    // read answer is a snapshot of pins at the accepting edge
    if (ar_hs)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = spp_pkg::RESP_OKAY;
      if (axi_req.araddr[spp_pkg::ADDR_W-1:2] == spp_pkg::OFF_CTRL[spp_pkg::ADDR_W-1:2])
      begin
        s_d.rdata = ctrl_rd;
      end
      else if (axi_req.araddr[spp_pkg::ADDR_W-1:2] == spp_pkg::OFF_CFG[spp_pkg::ADDR_W-1:2])
      begin
        s_d.rdata = cfg_rd;
      end
      else
      begin
        s_d.rdata = 32'h0000_0000;
        s_d.rresp = spp_pkg::RESP_SLVERR;
      end
    end
    else if (s_q.rvalid && axi_req.rready)
    begin
      s_d.rvalid = 1'b0;
    end
    // relies on the video module driving syncs even during ROM use
    s_d.vs_prev = vs_act;
    if (s_q.vs_prev && !vs_act)
    begin
      s_d.field_even = hs_act;
    end
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q            <= '0;
      s_q.ctrl       <= spp_pkg::CTRL_RST;
      s_q.cfg        <= spp_pkg::CFG_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // bus slave outputs
  always_comb
  begin
    axi_rsp         = '0;
    axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
    axi_rsp.wready  = !s_q.w_got && !s_q.bvalid;
    axi_rsp.bvalid  = s_q.bvalid;
    axi_rsp.bresp   = s_q.bresp;
    axi_rsp.arready = !s_q.rvalid;
    axi_rsp.rvalid  = s_q.rvalid;
    axi_rsp.rdata   = s_q.rdata;
    axi_rsp.rresp   = s_q.rresp;
  end

  // host port pins; ROM ownership forces chip select off and data drive off, strobe, rw and address still follow the register
  always_comb
  begin
    hp_o.cs_n = !s_q.ctrl[spp_pkg::B_HP_EN] || s_q.ctrl[spp_pkg::B_HP_CS_N]
                || rom_busy_i;
    hp_o.data_strobe_low = s_q.ctrl[spp_pkg::B_HP_STRB];
    hp_o.rw_n            = s_q.ctrl[spp_pkg::B_HP_RW];
    hp_o.addr            = s_q.ctrl[spp_pkg::B_HP_ADDR +: 4];
    hp_o.data_o          = s_q.ctrl[spp_pkg::B_HP_DATA +: 8];
    hp_o.data_oe = !s_q.ctrl[spp_pkg::B_HP_OE_N] && !rom_busy_i;
  end

  // board buffer enables and external resets
  assign gpio0_o     = rom_busy_i;
  assign gpio1_o     = s_q.ctrl[spp_pkg::B_GPIO1];
  assign vid_reset_n = s_q.ctrl[spp_pkg::B_VID_RST_N];
  assign tv_reset_n  = s_q.ctrl[spp_pkg::B_TV_RST_N];

  // open-drain lines only ever pull low; release hands the line to others
  assign display_channel_clock_o  = 1'b0;
  assign display_channel_data_o   = 1'b0;
  assign i2c_clk_o                = 1'b0;
  assign i2c_data_o               = 1'b0;
  assign display_channel_clock_oe = s_q.ctrl[spp_pkg::B_DDC_EN]
                                    && !s_q.ctrl[spp_pkg::B_DDC_CK_W];
  assign display_channel_data_oe  = s_q.ctrl[spp_pkg::B_DDC_EN]
                                    && !s_q.ctrl[spp_pkg::B_DDC_DA_W];
  assign i2c_clk_oe = s_q.ctrl[spp_pkg::B_I2C_EN] && !s_q.ctrl[spp_pkg::B_I2C_CK_W];
  assign i2c_data_oe = s_q.ctrl[spp_pkg::B_I2C_EN] && !s_q.ctrl[spp_pkg::B_I2C_DA_W];

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_ctrl_seq;
    s_q.aw_got && s_q.w_got && s_q.aw_addr[7:2] == 6'h00 && s_q.wstrb[3];
  endsequence

  sequence rd_ctrl_seq;
    ar_hs && axi_req.araddr[7:2] == 6'h00;
  endsequence

  sequence vs_fall_seq;
    s_q.vs_prev && !vs_act;
  endsequence

  a_cs_when_off: assert property (!s_q.ctrl[0] |-> hp_o.cs_n)
    else $error("chip select active while host port disabled");
  a_data_oe_off: assert property (s_q.ctrl[5] |-> !hp_o.data_oe)
    else $error("host data driven while output enable is off");
  a_rom_excl_host: assert property (rom_busy_i |-> gpio0_o && hp_o.cs_n && !hp_o.data_oe)
    else $error("host port active during ROM ownership");
  a_field_even_set: assert property (vs_fall_seq ##0 hs_act |=> s_q.field_even)
    else $error("even field not flagged");
  a_field_odd_set: assert property (vs_fall_seq ##0 !hs_act |=> !s_q.field_even)
    else $error("odd field not flagged");
  a_ddc_released: assert property (!s_q.ctrl[18] |-> !display_channel_clock_oe
                                   && !display_channel_data_oe)
    else $error("display channel driven while disabled");
  a_i2c_pull_low: assert property (s_q.ctrl[23] && !s_q.ctrl[24] |-> i2c_clk_oe && !i2c_clk_o)
    else $error("I2C clock not pulled low");
  a_gpio1_follow: assert property (wr_ctrl_seq |=> gpio1_o == $past(s_q.wdata[29]))
    else $error("second gpio did not follow written bit");
  a_ack_readback: assert property (rd_ctrl_seq |=> axi_rsp.rvalid
                                   && axi_rsp.rdata[4] == $past(hp_ack_i))
    else $error("acknowledge bit read back wrong");
  a_i2c_sense_rd: assert property (rd_ctrl_seq |=> axi_rsp.rdata[27] == $past(i2c_data_i))
    else $error("I2C data level read back wrong");
  a_reset_holds: assert property (@(posedge aclk) disable iff (1'b0)
                                  !aresetn |=> !vid_reset_n && !tv_reset_n && hp_o.cs_n)
    else $error("external resets not asserted after reset");

endmodule

// ### tb/spp_far_model.sv
`timescale 1ns/1ps
module spp_far_model (
  // clock
  input  wire logic       aclk,
  // host port
  input  wire logic       cs_n,
  input  wire logic       data_oe,
  input  wire logic [7:0] data_o,
  input  wire logic [7:0] far_data,
  output logic [7:0]      data_lvl,
  output logic            ack_n,
  // open-drain lines: ddc clk, ddc data, i2c clk, i2c data
  input  wire logic [3:0] line_oe,
  input  wire logic [3:0] line_pull,
  output logic [3:0]      line_lvl
);
  // slow device: acknowledge trails the chip select by a cycle
  always_ff @(posedge aclk)
    ack_n <= cs_n;
  // far side only drives the data bus while the block has let go
  assign data_lvl = data_oe ? data_o : far_data;
  // pull-up on every line, low as soon as anyone pulls
  assign line_lvl = ~(line_oe | line_pull);
endmodule

// ### tb/serial_parallel_pin_port_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %0t got %0h exp %0h", $time, (g), (e)); end end
module serial_parallel_pin_port_test;
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  spp_pkg::spp_axi_req_s req = '0;
  spp_pkg::spp_axi_rsp_s rsp;
  spp_pkg::spp_hp_s      hp;
  logic [7:0]            hp_lvl;
  logic [7:0]            far_data = 8'hA5;
  logic                  ack_n;
  logic                  rom_busy = 1'b0;
  logic                  gpio0;
  logic                  gpio1;
  logic                  gpio2 = 1'b1;
  logic                  vs = 1'b0;
  logic                  hs = 1'b0;
  logic                  va = 1'b0;
  logic [3:0]            oe;
  logic [3:0]            pull = 4'h0;
  logic [3:0]            lvl;
  logic                  vid_rn;
  logic                  tv_rn;
  logic [31:0]           st;
  logic [31:0]           d;
  logic [1:0]            r;
  int                    n_fail = 0;
  int                    n_checks = 0;

  // 50 MHz clock
  always #10 aclk = ~aclk;

  spp_port dut_u (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .hp_o(hp), .hp_data_i(hp_lvl), .hp_ack_i(ack_n), .rom_busy_i(rom_busy),
    .gpio0_o(gpio0), .gpio1_o(gpio1), .gpio2_i(gpio2),
    .vin_vsync_i(vs), .vin_hsync_i(hs), .vin_vactive_i(va),
    .display_channel_clock_i(lvl[3]), .display_channel_clock_o(),
    .display_channel_clock_oe(oe[3]), .display_channel_data_i(lvl[2]),
    .display_channel_data_o(), .display_channel_data_oe(oe[2]),
    .i2c_clk_i(lvl[1]), .i2c_clk_o(), .i2c_clk_oe(oe[1]),
    .i2c_data_i(lvl[0]), .i2c_data_o(), .i2c_data_oe(oe[0]),
    .vid_reset_n(vid_rn), .tv_reset_n(tv_rn));

  spp_far_model far_u (
    .aclk(aclk), .cs_n(hp.cs_n), .data_oe(hp.data_oe), .data_o(hp.data_o),
    .far_data(far_data), .data_lvl(hp_lvl), .ack_n(ack_n),
    .line_oe(oe), .line_pull(pull), .line_lvl(lvl));

  task automatic tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task automatic ran_out;
    begin
      n_fail++;
      $display("FAIL %0t bus wait ran out", $time);
      tally_and_finish();
    end
  endtask

  // write: both channels offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    int   n;
    begin
      aw = 1'b0;
      w = 1'b0;
      n = 0;
      @(posedge aclk);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= v;
      req.wstrb <= 4'hF;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do
      begin
        @(posedge aclk);
        n++;
        if (rsp.awready && !aw)
        begin
          aw = 1'b1;
          req.awvalid <= 1'b0;
        end
        if (rsp.wready && !w)
        begin
          w = 1'b1;
          req.wvalid <= 1'b0;
        end
      end while (!rsp.bvalid && n < 50);
      if (!rsp.bvalid)
        ran_out();
      r = rsp.bresp;
      req.bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    begin
      n = 0;
      @(posedge aclk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do
      begin
        @(posedge aclk);
        n++;
        if (rsp.arready)
          req.arvalid <= 1'b0;
      end while (!rsp.rvalid && n < 50);
      if (!rsp.rvalid)
        ran_out();
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
    end
  endtask

  // readback: stored bits plus what the pins show
  function automatic logic [31:0] exp_ctrl(input logic [31:0] s);
    logic [31:0] e;
    begin
      e = s & spp_pkg::CTRL_WMSK;
      e[4] = ack_n;
      e[13:6] = (!s[5] && !rom_busy) ? s[13:6] : far_data;
      e[21] = !(s[18] && !s[19]) && !pull[3];
      e[22] = !(s[18] && !s[20]) && !pull[2];
      e[26] = !(s[23] && !s[24]) && !pull[1];
      e[27] = !(s[23] && !s[25]) && !pull[0];
      e[30] = gpio2;
      return e;
    end
  endfunction

  task automatic wr_ctrl(input logic [31:0] v);
    begin
      axi_wr(spp_pkg::OFF_CTRL, v);
      `CHK(r, spp_pkg::RESP_OKAY)
      st = (v & spp_pkg::CTRL_WMSK) | (st & ~spp_pkg::CTRL_WMSK);
      @(negedge aclk);
    end
  endtask

  task automatic rd_chk;
    begin
      axi_rd(spp_pkg::OFF_CTRL);
      `CHK(d, exp_ctrl(st))
    end
  endtask

  // open-drain case: port enables, write bits and far-side pulls
  task automatic od(input logic [31:0] v, input logic [3:0] p);
    begin
      @(posedge aclk);
      pull <= p;
      wr_ctrl((st & ~32'h039C_0000) | v);
      `CHK(oe, {v[18] & !v[19], v[18] & !v[20], v[23] & !v[24], v[23] & !v[25]})
      rd_chk();
    end
  endtask

  // field case: polarity, hsync level, then an inactive-going vsync
  task automatic fld(input logic [2:0] c, input logic h, input logic act, input logic ev);
    begin
      axi_wr(spp_pkg::OFF_CFG, {29'h0, c});
      vs <= act;
      hs <= h;
      repeat (2) @(posedge aclk);
      vs <= ~act;
      repeat (3) @(posedge aclk);
      axi_rd(spp_pkg::OFF_CFG);
      `CHK(d[2:0], c)
      `CHK({d[11], d[8]}, {c[2], ev})
    end
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    st = spp_pkg::CTRL_RST;
    @(negedge aclk);
    `CHK({hp.cs_n, hp.data_oe, oe, vid_rn, tv_rn, gpio1}, 9'h100)
    rd_chk();
    $display("test reset done");
    wr_ctrl(32'hB31B_1685);
    `CHK({hp.cs_n, hp.data_strobe_low, hp.rw_n, hp.addr, hp.data_o, hp.data_oe}, 16'h58B5)
    `CHK({gpio0, gpio1, vid_rn, tv_rn}, 4'h7)
    rd_chk();
    @(posedge aclk);
    rom_busy <= 1'b1;
    @(negedge aclk);
    `CHK({gpio0, hp.cs_n, hp.data_oe}, 3'h6)
    rd_chk();
    @(posedge aclk);
    rom_busy <= 1'b0;
    gpio2 <= 1'b0;
    @(negedge aclk);
    `CHK({gpio0, hp.cs_n, hp.data_oe}, 3'h1)
    wr_ctrl(32'hB31B_16A4);
    `CHK({hp.cs_n, hp.data_oe}, 2'h2)
    rd_chk();
    $display("test host port done");
    od(32'h0084_0000, 4'h0);
    od(32'h0000_0000, 4'h0);
    od(32'h028C_0000, 4'hA);
    od(32'h039C_0000, 4'h0);
    $display("test open drain done");
    axi_wr(8'h08, 32'hFFFF_FFFF);
    `CHK(r, spp_pkg::RESP_SLVERR)
    axi_rd(8'h08);
    `CHK({r, d}, {spp_pkg::RESP_SLVERR, 32'h0})
    wr_ctrl(32'hFFFF_FFFF);
    rd_chk();
    $display("test access done");
    fld(3'h0, 1'b1, 1'b1, 1'b1);
    fld(3'h0, 1'b0, 1'b1, 1'b0);
    fld(3'h3, 1'b1, 1'b0, 1'b0);
    fld(3'h7, 1'b0, 1'b0, 1'b1);
    $display("test field done");
    tally_and_finish();
  end
endmodule
